// >>> hdl/dhrs_cfg.svh
`ifndef DHRS_CFG_SVH
`define DHRS_CFG_SVH
// ************************************************************
// timing figures, as printed, and derived cycle counts
// ************************************************************
`define DHRS_CLK_HZ           25000000
`define DHRS_REJECT_NS        5000
`define DHRS_ACCEPT_NS        9000
`define DHRS_BLANK_MAX_MS     120
`define DHRS_LOAD_MAX_MS      5
// reject limit: a low pulse up to this length is noise (round down)
`define DHRS_REJECT_CYC       ((`DHRS_REJECT_NS * 25) / 1000)
// accept limit: a low pulse of this length always resets (round up)
`define DHRS_ACCEPT_CYC       ((`DHRS_ACCEPT_NS * 25 + 999) / 1000)
// threshold used: midpoint of the tolerance band
`define DHRS_START_CYC        ((`DHRS_REJECT_CYC + `DHRS_ACCEPT_CYC) / 2)
// high spikes shorter than this are ignored once a low pulse has passed the threshold
`define DHRS_SPIKE_CYC        `DHRS_REJECT_CYC
`define DHRS_BLANK_CYC        (`DHRS_BLANK_MAX_MS * (`DHRS_CLK_HZ / 1000))
`define DHRS_LOAD_CYC         (`DHRS_LOAD_MAX_MS * (`DHRS_CLK_HZ / 1000))
`define DHRS_CNT_W            22
// settings store layout and reset values
`define DHRS_NVM_DEPTH        8
`define DHRS_NVM_AW           3
`define DHRS_ADDR_ID0         3'h0
`define DHRS_ADDR_ID1         3'h1
`define DHRS_ADDR_ID2         3'h2
`define DHRS_ADDR_COMMON_VOLTAGE_SETTING        3'h3
`define DHRS_ADDR_CFG0        3'h4
`define DHRS_ADDR_LAST        3'h7
`define DHRS_RST_BYTE         8'h00
`define DHRS_RST_SLEEP_OUT    1'b0
`define DHRS_RST_DISP_ON      1'b0
`endif

// >>> hdl/dhrs_pkg.sv
`default_nettype none
package dhrs_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    DHRS_RUN     = 3'b000,
    DHRS_LOW     = 3'b001,
    DHRS_BLANK   = 3'b010,
    DHRS_HOLD    = 3'b011,
    DHRS_LOAD    = 3'b100,
    DHRS_DONE    = 3'b101
  } dhrs_state_t;
  // settings reloaded from the store
  typedef struct packed {
    logic [7:0] id0;
    logic [7:0] id1;
    logic [7:0] id2;
    logic [7:0] common_voltage_setting;
    logic [7:0] cfg0;
  } dhrs_regs_t;
  // mode flags
  typedef struct packed {
    logic sleep_out;
    logic disp_on;
  } dhrs_mode_t;
endpackage : dhrs_pkg
`default_nettype wire

// >>> hdl/dhrs_nvm.sv
`include "dhrs_cfg.svh"
`default_nettype none
// ************************************************************
// settings store: registered read port, write port for programming
// ************************************************************
module dhrs_nvm
  import dhrs_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     clk_en,
  input  wire logic [`DHRS_NVM_AW-1:0]  rd_addr,
  output logic      [7:0]               rd_data,
  input  wire logic                     wr_en,
  input  wire logic [`DHRS_NVM_AW-1:0]  wr_addr,
  input  wire logic [7:0]               wr_data
);
  logic [7:0] mem_q [`DHRS_NVM_DEPTH];
  logic [7:0] rd_q;
  logic [7:0] rd_d;

  // read mux
  always_comb begin
    rd_d = mem_q[rd_addr];
  end

  // storage and read register; contents survive resets
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      rd_q <= rd_d;
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
    end
  end

  assign rd_data = rd_q;
endmodule : dhrs_nvm
`default_nettype wire

// >>> hdl/dhrs_seq.sv
// How it works
// (R1) low reset input requests full chip init
// (R2) reject under 5us, reset over 9us
// (R3) between limits either outcome is acceptable
// (R4) short high spikes inside low ignored; code ignores them only after START_CYC, earlier a high restarts the low count
// (R5) release reloads id, common_voltage_setting, settings from store
// (R6) sleep-out reset runs blanking, max 120ms
// (R7) sleep-in reset keeps display blank only
// (R8) completion restores all hardware-reset defaults
// (R9) sleep-in completion within 5ms of release
// (R10) sleep-out completion within 120ms of release
// (R11) host waits 5ms before any command
// (R12) host waits 120ms before sleep exit
// (R13) synchronise input, count low width deterministically
`include "dhrs_cfg.svh"
`default_nettype none
module dhrs_seq
  import dhrs_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic                     hw_reset_in_n,
  input  wire logic                     cmd_sleep_out,
  input  wire logic                     cmd_sleep_in,
  input  wire logic                     cmd_disp_on,
  input  wire logic                     cmd_disp_off,
  input  wire logic                     nvm_wr_en,
  input  wire logic [`DHRS_NVM_AW-1:0]  nvm_wr_addr,
  input  wire logic [7:0]               nvm_wr_data,
  output logic                          in_reset,
  output logic                          ready,
  output logic                          panel_blank,
  output dhrs_regs_t                    regs,
  output dhrs_mode_t                    mode
);
  localparam logic [`DHRS_CNT_W-1:0] START_CYC = `DHRS_CNT_W'(`DHRS_START_CYC);
  localparam logic [`DHRS_CNT_W-1:0] SPIKE_CYC = `DHRS_CNT_W'(`DHRS_SPIKE_CYC);
  localparam logic [`DHRS_CNT_W-1:0] BLANK_CYC = `DHRS_CNT_W'(`DHRS_BLANK_CYC);
  localparam logic [`DHRS_CNT_W-1:0] LOAD_CYC  = `DHRS_CNT_W'(`DHRS_LOAD_CYC);

  // saturating increment used by all three counters (low, spike, timer)
  function automatic logic [`DHRS_CNT_W-1:0] sat_inc(input logic [`DHRS_CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + `DHRS_CNT_W'(1);
  endfunction : sat_inc

  // ************************************************************
  // input synchroniser
  // ************************************************************
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       lvl_q;
  logic       lvl_d;

  always_comb begin
    sync_d = {sync_q[1:0], hw_reset_in_n};
    lvl_d  = (sync_q[2] == sync_q[1]) ? sync_q[2] : lvl_q;  // R13
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_q <= 3'h7;
      lvl_q  <= 1'b1;
    end else if (clk_en) begin
      sync_q <= sync_d;
      lvl_q  <= lvl_d;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  dhrs_state_t                st_q, st_d;
  logic [`DHRS_CNT_W-1:0]     low_q, low_d;
  logic [`DHRS_CNT_W-1:0]     hi_q, hi_d;
  logic [`DHRS_CNT_W-1:0]     tmr_q, tmr_d;
  logic                       was_out_q, was_out_d;
  logic [`DHRS_NVM_AW-1:0]    addr_q, addr_d;
  logic                       rvalid_q, rvalid_d;
  logic [`DHRS_NVM_AW-1:0]    raddr_q, raddr_d;
  dhrs_regs_t                 regs_q, regs_d;
  dhrs_mode_t                 mode_q, mode_d;
  logic                       inr_q, inr_d;
  logic                       rdy_q, rdy_d;
  logic                       blank_q, blank_d;
  logic [7:0]                 nvm_rd;

  always_comb begin
    st_d      = st_q;
    low_d     = low_q;
    hi_d      = hi_q;
    tmr_d     = tmr_q;
    was_out_d = was_out_q;
    addr_d    = addr_q;
    rvalid_d  = 1'b0;
    raddr_d   = addr_q;
    regs_d    = regs_q;
    mode_d    = mode_q;
    // low-width and spike counters
    if (!lvl_q) begin
      low_d = sat_inc(low_q);  // R13
      hi_d  = '0;
    end else begin
      hi_d  = sat_inc(hi_q);
    end
    unique case (st_q)
      DHRS_RUN: begin
        if (cmd_sleep_out) mode_d.sleep_out = 1'b1;
        if (cmd_sleep_in)  mode_d.sleep_out = 1'b0;
        if (cmd_disp_on)   mode_d.disp_on   = 1'b1;
        if (cmd_disp_off)  mode_d.disp_on   = 1'b0;
        if (lvl_q) begin
          low_d = '0;
        end else if (low_q >= START_CYC) begin  // R1 R2 R3
          st_d      = DHRS_LOW;
          was_out_d = mode_q.sleep_out;
          tmr_d     = '0;
        end
      end
      DHRS_LOW: begin
        // line still low or only a short spike: stay
        tmr_d = sat_inc(tmr_q);
        if (lvl_q && hi_q >= SPIKE_CYC) begin  // R4
          tmr_d  = '0;
          addr_d = '0;
          st_d   = was_out_q ? DHRS_BLANK : DHRS_HOLD;  // R6 R7
        end
      end
      DHRS_BLANK: begin
        tmr_d = sat_inc(tmr_q);
        if (tmr_q >= BLANK_CYC - LOAD_CYC) begin  // R6 R10
          st_d  = DHRS_LOAD;
          tmr_d = '0;
        end
      end
      DHRS_HOLD: begin
        st_d = DHRS_LOAD;  // R7
      end
      DHRS_LOAD: begin
        tmr_d    = sat_inc(tmr_q);
        rvalid_d = 1'b1;  // R5
        addr_d   = addr_q + `DHRS_NVM_AW'(1);
        if (addr_q == `DHRS_ADDR_LAST) st_d = DHRS_DONE;
      end
      DHRS_DONE: begin
        // defaults; reload lands in regs as reads return
        mode_d.sleep_out = `DHRS_RST_SLEEP_OUT;  // R8
        mode_d.disp_on   = `DHRS_RST_DISP_ON;  // R8
        low_d            = '0;
        st_d             = DHRS_RUN;  // R9
      end
      default: st_d = DHRS_RUN;
    endcase
    // store read data arrives one cycle after its address
    if (rvalid_q) begin
      unique case (raddr_q)
        `DHRS_ADDR_ID0:  regs_d.id0  = nvm_rd;  // R5
        `DHRS_ADDR_ID1:  regs_d.id1  = nvm_rd;
        `DHRS_ADDR_ID2:  regs_d.id2  = nvm_rd;
        `DHRS_ADDR_COMMON_VOLTAGE_SETTING: regs_d.common_voltage_setting = nvm_rd;
        `DHRS_ADDR_CFG0: regs_d.cfg0 = nvm_rd;
        default:         regs_d      = regs_d;
      endcase
    end
    // outputs; host honours its 5ms/120ms waits by counting cycles since release, not from ready
    inr_d   = (st_d != DHRS_RUN);
    rdy_d   = (st_d == DHRS_RUN);  // R11 R12
    blank_d = (st_d != DHRS_RUN) || !mode_d.disp_on || !mode_d.sleep_out;  // R7
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q      <= DHRS_RUN;
      low_q     <= '0;
      hi_q      <= '0;
      tmr_q     <= '0;
      was_out_q <= 1'b0;
      addr_q    <= '0;
      rvalid_q  <= 1'b0;
      raddr_q   <= '0;
      regs_q    <= {5{`DHRS_RST_BYTE}};
      mode_q    <= '{sleep_out: `DHRS_RST_SLEEP_OUT, disp_on: `DHRS_RST_DISP_ON};
      inr_q     <= 1'b0;
      rdy_q     <= 1'b1;
      blank_q   <= 1'b1;
    end else if (clk_en) begin
      st_q      <= st_d;
      low_q     <= low_d;
      hi_q      <= hi_d;
      tmr_q     <= tmr_d;
      was_out_q <= was_out_d;
      addr_q    <= addr_d;
      rvalid_q  <= rvalid_d;
      raddr_q   <= raddr_d;
      regs_q    <= regs_d;
      mode_q    <= mode_d;
      inr_q     <= inr_d;
      rdy_q     <= rdy_d;
      blank_q   <= blank_d;
    end
  end

  // ************************************************************
  // settings store
  // ************************************************************
  dhrs_nvm u_nvm (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .rd_addr (addr_q),
    .rd_data (nvm_rd),
    .wr_en   (nvm_wr_en),
    .wr_addr (nvm_wr_addr),
    .wr_data (nvm_wr_data)
  );

  assign in_reset    = inr_q;
  assign ready       = rdy_q;
  assign panel_blank = blank_q;
  assign regs        = regs_q;
  assign mode        = mode_q;
endmodule : dhrs_seq
`default_nettype wire

// >>> tb/dhrs_host.sv
`default_nettype none
// ****************************************
// host model: drives the reset line
// ****************************************
module dhrs_host #(
  parameter int CMD_WAIT = 125000,
  parameter int SLP_WAIT = 3000000
) (
  input  wire logic ref_clk,
  output logic      hw_reset_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int rel_cyc = 0;
  initial hw_reset_in_n = 1'b1;
  // cycles since the line was last released
  always @(posedge ref_clk) rel_cyc <= hw_reset_in_n ? rel_cyc + 1 : 0;
  // low for lo cycles, then high for hi cycles
  task automatic drive(input int lo, input int hi);
    hw_reset_in_n = 1'b0;
    repeat (lo) @(posedge ref_clk);
    #1 hw_reset_in_n = 1'b1;
    for (int i = 0; i < hi; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask : drive
  // hold off commands, longer for sleep exit
  task automatic wait_gap(input bit slp);
    while (rel_cyc < (slp ? SLP_WAIT : CMD_WAIT)) begin
      @(posedge ref_clk);
      #1;
    end
  endtask : wait_gap
endmodule : dhrs_host
`default_nettype wire

// >>> tb/dhrs_seq_chk.sv
`include "dhrs_cfg.svh"
`default_nettype none
// ****************************************
// port checker for the reset sequencer
// ****************************************
module dhrs_seq_chk
  import dhrs_pkg::*;
(
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire logic                    clk_en,
  input wire logic                    hw_reset_in_n,
  input wire logic                    cmd_sleep_out,
  input wire logic                    cmd_sleep_in,
  input wire logic                    cmd_disp_on,
  input wire logic                    cmd_disp_off,
  input wire logic                    nvm_wr_en,
  input wire logic [`DHRS_NVM_AW-1:0] nvm_wr_addr,
  input wire logic [7:0]              nvm_wr_data,
  input wire logic                    in_reset,
  input wire logic                    ready,
  input wire logic                    panel_blank,
  input wire dhrs_regs_t              regs,
  input wire dhrs_mode_t              mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [21:0] lo_q, hi_q, lo_run_q, hi_run_q;
  logic        so_q;
  logic [7:0]  mem_q [8];
  // raw line run lengths, last runs held past the edge, origin mode, store mirror
  always_ff @(posedge ref_clk) begin
    lo_q <= (!rst_n || hw_reset_in_n) ? 22'h0 : lo_q + 22'h1;
    hi_q <= (!rst_n || !hw_reset_in_n) ? 22'h0 : hi_q + 22'h1;
    lo_run_q <= !rst_n ? 22'h0 : (!hw_reset_in_n ? lo_q + 22'h1 : lo_run_q);
    hi_run_q <= !rst_n ? 22'h0 : (hw_reset_in_n ? hi_q + 22'h1 : hi_run_q);
    if (!in_reset) so_q <= mode.sleep_out;
    if (clk_en && nvm_wr_en) mem_q[nvm_wr_addr] <= nvm_wr_data;
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  short_reject_a: assert property ($rose(in_reset) |-> lo_run_q >= 22'h7d)
    else $error("reset began after a low under 5us");
  long_accept_a: assert property (lo_q == 22'h104 |-> in_reset)
    else $error("long low did not reset");
  spike_hold_a: assert property ($fell(in_reset) |-> hi_run_q >= 22'h7d)
    else $error("reset ended on a short high");
  reset_blank_a: assert property (in_reset |-> panel_blank)
    else $error("panel shown during reset");
  sleep_in_time_a: assert property (in_reset && !so_q |-> hi_q < 22'h1e848)
    else $error("sleep-in reset too long");
  sleep_out_time_a: assert property (in_reset && so_q |-> hi_q < 22'h2dc6c0)
    else $error("sleep-out reset too long");
  reset_defaults_a: assert property ($fell(in_reset) |-> mode == '0 && ready)
    else $error("mode not default after reset");
  store_reload_a: assert property ($fell(in_reset) |=> regs == {mem_q[0], mem_q[1], mem_q[2], mem_q[3], mem_q[4]})
    else $error("settings not reloaded");
  cover property ($rose(in_reset));
  cover property ($fell(in_reset));
  cover property (in_reset && so_q);
endmodule : dhrs_seq_chk
`default_nettype wire

// >>> tb/dhrs_seq_test.sv
`include "dhrs_cfg.svh"
`default_nettype none
// ****************************************
// testbench for the reset sequencer
// ****************************************
module dhrs_seq_test
  import dhrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    ref_clk, rst_n, clk_en, hw_reset_in_n, nvm_wr_en;
  logic                    cmd_sleep_out, cmd_sleep_in, cmd_disp_on, cmd_disp_off;
  logic                    in_reset, ready, panel_blank;
  logic [`DHRS_NVM_AW-1:0] nvm_wr_addr;
  logic [7:0]              nvm_wr_data;
  dhrs_regs_t              regs;
  dhrs_mode_t              mode;
  logic [7:0]              exp_mem [8];
  int                      exp_so, exp_on, mismatches, cmp_count, n;
  int                      seq [6] = '{0, 2, 3, 2, 1, 0};
  dhrs_seq u_dhrs_seq (.ref_clk, .rst_n, .clk_en, .hw_reset_in_n, .cmd_sleep_out, .cmd_sleep_in,
    .cmd_disp_on, .cmd_disp_off, .nvm_wr_en, .nvm_wr_addr, .nvm_wr_data, .in_reset, .ready,
    .panel_blank, .regs, .mode);
  dhrs_host #(.CMD_WAIT(200), .SLP_WAIT(400)) u_dhrs_host (.ref_clk, .hw_reset_in_n);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic check(input string nm, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // status after completion: ready, blank, mode cleared
  task automatic done_chk(input logic [39:0] r);
    n = 0;
    while (in_reset !== 1'b0 && n < 1000) begin
      step(1);
      n++;
    end
    check("status", {3'h3, 2'h0, r}, {in_reset, ready, panel_blank, mode, regs});
  endtask : done_chk
  // one-cycle command pulse, model follows when live
  task automatic cmd(input int k, input bit live);
    {cmd_sleep_out, cmd_sleep_in, cmd_disp_on, cmd_disp_off} = 4'h8 >> k;
    step(1);
    {cmd_sleep_out, cmd_sleep_in, cmd_disp_on, cmd_disp_off} = 4'h0;
    step(2);
    if (live) begin
      if (k < 2) exp_so = (k == 0);
      else exp_on = (k == 2);
      check("mode", {exp_so[0], exp_on[0], !(exp_so[0] && exp_on[0])}, {mode, panel_blank});
    end
  endtask : cmd
  // fill the store with random bytes
  task automatic prog();
    for (int a = 0; a < 8; a++) begin
      nvm_wr_en = 1'b1;
      nvm_wr_addr = a[2:0];
      nvm_wr_data = 8'($urandom);
      exp_mem[a] = nvm_wr_data;
      step(1);
    end
    nvm_wr_en = 1'b0;
  endtask : prog
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
  // main sequence
  initial begin
    {rst_n, clk_en, cmd_sleep_out, cmd_sleep_in, cmd_disp_on, cmd_disp_off, nvm_wr_en} = 7'h20;
    nvm_wr_addr = 3'h0;
    nvm_wr_data = 8'h00;
    {mismatches, cmp_count, exp_so, exp_on} = '0;
    n = $urandom(63873);
    step(5);
    rst_n = 1'b1;
    done_chk(40'h0);
    prog();
    u_dhrs_host.drive(100, 20);
    check("in_reset", 1'b0, in_reset);
    fork
      u_dhrs_host.drive(260, 0);
      begin
        step(230);
        cmd(0, 1'b0);
      end
    join
    check("busy", 2'h3, {in_reset, panel_blank});
    done_chk({exp_mem[0], exp_mem[1], exp_mem[2], exp_mem[3], exp_mem[4]});
    u_dhrs_host.wait_gap(1'b0);
    prog();
    u_dhrs_host.drive(260, 60);
    check("spike", 1'b1, in_reset);
    // frozen: the high run must not grow into a release
    clk_en = 1'b0;
    step(100);
    check("frozen", 1'b1, in_reset);
    clk_en = 1'b1;
    u_dhrs_host.drive(100, 0);
    done_chk({exp_mem[0], exp_mem[1], exp_mem[2], exp_mem[3], exp_mem[4]});
    u_dhrs_host.wait_gap(1'b1);
    foreach (seq[i]) cmd(seq[i], 1'b1);
    u_dhrs_host.drive(260, 2000);
    check("blanking", 2'h3, {in_reset, panel_blank});
    rst_n = 1'b0;
    step(5);
    rst_n = 1'b1;
    done_chk(40'h0);
    u_dhrs_host.drive(260, 0);
    done_chk({exp_mem[0], exp_mem[1], exp_mem[2], exp_mem[3], exp_mem[4]});
    print_verdict();
  end
endmodule : dhrs_seq_test
bind dhrs_seq dhrs_seq_chk u_chk (.ref_clk, .rst_n, .clk_en, .hw_reset_in_n, .cmd_sleep_out,
  .cmd_sleep_in, .cmd_disp_on, .cmd_disp_off, .nvm_wr_en, .nvm_wr_addr, .nvm_wr_data,
  .in_reset, .ready, .panel_blank, .regs, .mode);
`default_nettype wire
